// ### rtl/dhp_pkg.sv
// Shared constants for the display host register port.
package dhp_pkg;

  // Interface-family strap pattern that enables the register-content port
  localparam logic [1:0] FAMILY_REG_CONTENT = 2'h1;

  // Bus-format strap codes
  localparam logic [2:0] FMT_16 = 3'h0;
  localparam logic [2:0] FMT_16P2 = 3'h1;
  localparam logic [2:0] FMT_18 = 3'h2;
  localparam logic [2:0] FMT_8X3 = 3'h3;
  localparam logic [1:0] FMT_SERIAL_HI = 2'h3;

  // Serial start byte: upper five identification bits
  localparam logic [4:0] SERIAL_ID_HIGH = 5'h0e;

  // Index that addresses the frame memory
  localparam logic [7:0] MEM_INDEX_DEFAULT = 8'h22;

  // Widths and depths
  localparam int PIX_W = 18;
  localparam int CMD_W = 16;
  localparam int IDX_W = 8;
  localparam int FIFO_DEPTH = 4;

  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_READ_LATCH = 8'h08;

  // Field positions and reset values
  localparam int CTRL_VIDEO_BIT = 0;
  localparam int ST_OVERRUN_BIT = 15;
  localparam logic CTRL_VIDEO_RESET = 1'b0;

  // Serial receiver states
  typedef enum logic [2:0] {
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_SKIP = 3'b100
  } dhp_ser_e;

endpackage

// ### rtl/dhp_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module dhp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Pins in, filtered levels out
  input wire logic [W-1:0] pinRaw,
  output logic [W-1:0] pinNow
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end
    else
    begin
      stage1 <= pinRaw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit only moves once the last two stages agree
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clock)
    begin
      if (srst)
        pinNow[i] <= INIT[i];
      else if (stage2[i] == stage3[i])
        pinNow[i] <= stage3[i];
    end
  end
endmodule // dhp_sync
`default_nettype wire

// ### rtl/dhp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dhp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdPtr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (push)
      store[wrPtr] <= inData;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == LAST_PTR) ? '0 : wrPtr + 1'b1;
      if (pop)
        rdPtr <= (rdPtr == LAST_PTR) ? '0 : rdPtr + 1'b1;
      count <= next_count;
      inReady <= next_count != FULL_COUNT;
      outValid <= next_count != '0;
    end
  end
endmodule // dhp_fifo
`default_nettype wire

// ### rtl/dhp_host_port.sv
// Host-side register and frame-memory port of a TFT display driver.
// Operation
// [R1] Interface-family straps 0,1 select the register-content port; other patterns idle it.
// [R2] With video enable set, host pixel data is dropped; registers still go through.
// [R3] Only register-content registers are reachable here; command-parameter group stays apart.
// [R4] Host port takes 18, 16, 8-bit parallel in both strobe styles, or serial.
// [R5] Host transfers count only while chip select is low.
// [R6] Register-or-data select picks index path or register/memory path.
// [R7] Bus-format straps choose bus width and transfer format.
// [R8] A write with select 0 loads the index pointer.
// [R9] A write with select 1 goes where the index pointer points.
// [R10] Two 18-bit latches stage frame-memory writes and reads.
// [R11] Write latch empties into frame memory without host action.
// [R12] Reads return the read latch, so the first read is stale.
// [R13] With chip select high, strobes change no index, latch or register.
// [R14] Strobe-style strap: 0 write/read strobes, 1 enable with direction line.
// [R15] Format 000 16-bit, 001 16+2, 010 18-bit, 011 three bytes, 11x serial.
// [R16] 8080 style: write strobe low writes, read strobe low reads, select splits target.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port #(
  parameter logic [7:0] MEM_INDEX = dhp_pkg::MEM_INDEX_DEFAULT,
  parameter int FIFO_DEPTH = dhp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host bus pins
  input wire logic chipSelectN,
  input wire logic regOrDataSelect,
  input wire logic writeOrEnableStrobe,
  input wire logic readOrDirectionStrobe,
  input wire logic [17:0] hostDataIn,
  output logic [17:0] hostDataOut,
  output logic hostDataOe,
  input wire logic serialDataIn,
  // Straps
  input wire logic [1:0] interfaceFamilyStraps,
  input wire logic [2:0] busFormatStraps,
  input wire logic strobeStyleSelect,
  // Control register side
  output logic regWrValid,
  output logic [7:0] regWrIndex,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  // Frame memory side
  output logic memWrValid,
  output logic [17:0] memWrData,
  input wire logic memWrReady,
  output logic memRdReq,
  input wire logic [17:0] memRdData,
  input wire logic memRdValid
);
  localparam int SW = 29;
  localparam logic [SW-1:0] SYNC_INIT = {1'b1, 1'b0, 2'h3, 25'h0000000};

  logic [SW-1:0] pinRaw;
  logic [SW-1:0] pinNow;
  logic csN;
  logic sel;
  logic wrs;
  logic rds;
  logic [17:0] din;
  logic sdi;
  logic [1:0] fam;
  logic [2:0] fmt;
  logic style;
  logic famActive;
  logic serialMode;
  logic parMode;
  logic wrActive;
  logic rdActive;
  logic wrPrev;
  logic rdPrev;
  logic sclPrev;
  logic wrEnd;
  logic rdStart;
  logic rdEnd;
  logic sclRise;
  dhp_pkg::dhp_ser_e serState;
  logic [2:0] serBitCnt;
  logic [6:0] serShift;
  logic serRs;
  logic [7:0] newByte;
  logic serByteDone;
  logic pieceValid;
  logic pieceRs;
  logic [17:0] pieceData;
  logic [1:0] pieceCnt;
  logic [17:0] accum;
  logic [17:0] next_accum;
  logic lastPiece;
  logic [17:0] pixel;
  logic [15:0] regData;
  logic [7:0] indexPtr;
  logic memTarget;
  logic dataTake;
  logic pixelLoad;
  logic [17:0] wrLatch;
  logic wrLatchFull;
  logic [17:0] readLatch;
  logic [17:0] readWord;
  logic [17:0] hostStatus;
  logic fifoInReady;
  logic latchPush;
  logic overrun;
  logic videoPortEnable;
  logic memRdPending;
  logic apbWrite;

  assign pinRaw = {chipSelectN, regOrDataSelect, writeOrEnableStrobe, readOrDirectionStrobe,
                   hostDataIn, serialDataIn, interfaceFamilyStraps, busFormatStraps, strobeStyleSelect};

  dhp_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
    .clock(clock),
    .srst(srst),
    .pinRaw(pinRaw),
    .pinNow(pinNow)
  );

  assign csN = pinNow[28];
  assign sel = pinNow[27];
  assign wrs = pinNow[26];
  assign rds = pinNow[25];
  assign din = pinNow[24:7];
  assign sdi = pinNow[6];
  assign fam = pinNow[5:4];
  assign fmt = pinNow[3:1];
  assign style = pinNow[0];

  assign famActive = fam == dhp_pkg::FAMILY_REG_CONTENT; // [R1] [R3]
  assign serialMode = fmt[2:1] == dhp_pkg::FMT_SERIAL_HI; // [R7] [R15]
  assign parMode = famActive & ~serialMode & ~csN; // [R5] [R13]
  // 8080: active-low strobes; 6800: enable high qualified by direction
  assign wrActive = style ? (wrs & ~rds) : ~wrs; // [R14] [R16]
  assign rdActive = style ? (wrs & rds) : ~rds; // [R14] [R16]
  // Data is taken as the write strobe ends so setup on the pins is met
  assign wrEnd = parMode & wrPrev & ~wrActive; // [R4]
  assign rdStart = parMode & ~rdPrev & rdActive;
  assign rdEnd = parMode & rdPrev & ~rdActive;
  // In serial mode the select pin carries the shift clock
  assign sclRise = famActive & serialMode & ~csN & ~sclPrev & sel; // [R4] [R5]
  assign newByte = {serShift, sdi};
  assign serByteDone = sclRise && serBitCnt == 3'h7;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wrPrev <= 1'b0;
      rdPrev <= 1'b0;
      sclPrev <= 1'b0;
    end
    else
    begin
      wrPrev <= wrActive;
      rdPrev <= rdActive;
      sclPrev <= sel;
    end
  end

  // Serial receiver: start byte, then write bytes; serial reads are skipped
  always_ff @(posedge clock)
  begin
    if (srst || csN)
    begin
      serState <= dhp_pkg::SER_START;
      serBitCnt <= 3'h0;
      serShift <= 7'h00;
      serRs <= 1'b0;
    end
    else if (sclRise)
    begin
      serShift <= newByte[6:0];
      serBitCnt <= serBitCnt + 3'h1;
      if (serBitCnt == 3'h7)
      begin
        case (serState)
          dhp_pkg::SER_START:
          begin
            serRs <= newByte[1];
            if (newByte[7:2] == {dhp_pkg::SERIAL_ID_HIGH, fmt[0]} && !newByte[0])
              serState <= dhp_pkg::SER_DATA;
            else
              serState <= dhp_pkg::SER_SKIP;
          end
          dhp_pkg::SER_DATA: serState <= dhp_pkg::SER_DATA;
          dhp_pkg::SER_SKIP: serState <= dhp_pkg::SER_SKIP;
          default: serState <= dhp_pkg::SER_SKIP;
        endcase
      end
    end
  end

  // One write piece from either the parallel or the serial side
  always_comb
  begin
    pieceValid = 1'b0;
    pieceRs = 1'b0;
    pieceData = 18'h00000;
    if (wrEnd)
    begin
      pieceValid = 1'b1;
      pieceRs = sel; // [R6]
      pieceData = din;
    end
    else if (serByteDone && serState == dhp_pkg::SER_DATA)
    begin
      pieceValid = 1'b1;
      pieceRs = serRs; // [R6]
      pieceData = {10'h000, newByte};
    end
  end

  assign memTarget = indexPtr == MEM_INDEX;

  // Pixel and command assembly per bus format
  always_comb
  begin
    next_accum = accum;
    lastPiece = 1'b1;
    if (serialMode)
    begin
      next_accum = {accum[9:0], pieceData[7:0]};
      lastPiece = pieceCnt == 2'h1;
    end
    else
    begin
      case (fmt) // [R7] [R15]
        dhp_pkg::FMT_16P2:
        begin
          if (pieceCnt == 2'h0)
          begin
            next_accum = {pieceData[15:0], 2'h0};
            lastPiece = !memTarget;
          end
          else
            next_accum = {accum[17:2], pieceData[1:0]};
        end
        dhp_pkg::FMT_8X3:
        begin
          next_accum = {accum[11:0], pieceData[7:2]};
          lastPiece = !memTarget || pieceCnt == 2'h2;
        end
        default: next_accum = pieceData;
      endcase
    end
  end

  // 16-bit words widen to 18 bits by repeating the top bit of red and blue
  assign pixel = (serialMode || fmt == dhp_pkg::FMT_16)
    ? {next_accum[15:11], next_accum[15], next_accum[10:5], next_accum[4:0], next_accum[4]}
    : next_accum;
  assign regData = serialMode ? next_accum[15:0] : pieceData[15:0];
  // Display data comes from the video port while it is enabled
  assign dataTake = pieceValid & pieceRs & ~(memTarget & videoPortEnable); // [R2]
  assign pixelLoad = dataTake & lastPiece & memTarget; // [R9]

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      indexPtr <= 8'h00;
      pieceCnt <= 2'h0;
      accum <= 18'h00000;
    end
    else if (pieceValid && !pieceRs)
    begin
      indexPtr <= pieceData[7:0]; // [R8]
      pieceCnt <= 2'h0;
    end
    else if (dataTake)
    begin
      accum <= next_accum;
      pieceCnt <= lastPiece ? 2'h0 : pieceCnt + 2'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      regWrValid <= 1'b0;
      regWrIndex <= 8'h00;
      regWrData <= 16'h0000;
    end
    else
    begin
      regWrValid <= dataTake & lastPiece & ~memTarget; // [R9]
      if (dataTake && lastPiece && !memTarget)
      begin
        regWrIndex <= indexPtr; // [R9]
        regWrData <= regData;
      end
    end
  end

  // Write latch drains into the FIFO on its own
  assign latchPush = wrLatchFull & fifoInReady; // [R11]

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wrLatch <= 18'h00000;
      wrLatchFull <= 1'b0;
    end
    else if (pixelLoad)
    begin
      wrLatch <= pixel; // [R10] [R11]
      wrLatchFull <= 1'b1;
    end
    else if (latchPush)
      wrLatchFull <= 1'b0; // [R11]
  end

  dhp_fifo #(.WIDTH(dhp_pkg::PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .inValid(wrLatchFull),
    .inData(wrLatch),
    .inReady(fifoInReady),
    .outValid(memWrValid),
    .outData(memWrData),
    .outReady(memWrReady)
  );

  // Read path: the host sees the previous fetch, then a new fetch starts
  assign readWord = (fmt == dhp_pkg::FMT_18)
    ? readLatch
    : {2'h0, readLatch[17:13], readLatch[11:6], readLatch[5:1]};
  assign hostStatus = {8'h00, wrLatchFull, overrun, indexPtr};

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      readLatch <= 18'h00000;
      memRdReq <= 1'b0;
      memRdPending <= 1'b0;
    end
    else
    begin
      if (memRdValid)
        readLatch <= memRdData; // [R10] [R12]
      memRdReq <= rdEnd & sel & memTarget & ~memRdPending; // [R12]
      if (rdEnd && sel && memTarget)
        memRdPending <= 1'b1;
      else if (memRdValid)
        memRdPending <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hostDataOut <= 18'h00000;
      hostDataOe <= 1'b0;
    end
    else
    begin
      hostDataOe <= parMode & rdActive; // [R5] [R16]
      if (rdStart)
      begin
        if (!sel)
          hostDataOut <= hostStatus; // [R6] [R16]
        else if (memTarget)
          hostDataOut <= readWord; // [R12]
        else
          hostDataOut <= {2'h0, regRdData};
      end
    end
  end

  // APB slave: zero wait states, unmapped addresses answer with an error
  assign apbWrite = psel & penable & pready & pwrite;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr <= 1'b0;
        case (paddr)
          dhp_pkg::ADDR_CTRL: prdata <= {31'h00000000, videoPortEnable};
          dhp_pkg::ADDR_STATUS:
            prdata <= {14'h0000, serialMode, wrLatchFull, overrun, famActive, style, fmt, fam, indexPtr};
          dhp_pkg::ADDR_READ_LATCH: prdata <= {14'h0000, readLatch};
          default:
          begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      videoPortEnable <= dhp_pkg::CTRL_VIDEO_RESET;
    else if (apbWrite && paddr == dhp_pkg::ADDR_CTRL)
      videoPortEnable <= pwdata[dhp_pkg::CTRL_VIDEO_BIT]; // [R2]
  end

  // A new overrun in the clearing cycle keeps the flag set
  always_ff @(posedge clock)
  begin
    if (srst)
      overrun <= 1'b0;
    else if (pixelLoad && wrLatchFull && !latchPush)
      overrun <= 1'b1;
    else if (apbWrite && paddr == dhp_pkg::ADDR_STATUS && pwdata[dhp_pkg::ST_OVERRUN_BIT])
      overrun <= 1'b0;
  end

  a_family_gate: assert property (@(posedge clock) disable iff (srst) // [R1]
    regWrValid |-> $past(famActive))
    else $error("register write while family straps deselect the port");

  a_cp_isolated: assert property (@(posedge clock) disable iff (srst) // [R3]
    !famActive |=> $stable(indexPtr))
    else $error("index moved while another interface family is selected");

  a_video_block: assert property (@(posedge clock) disable iff (srst) // [R2]
    (wrEnd && sel && memTarget && videoPortEnable) |=> ($stable(wrLatch) && !$rose(wrLatchFull)))
    else $error("host pixel taken while video port enabled");

  a_cs_gate: assert property (@(posedge clock) disable iff (srst) // [R13]
    csN |=> ($stable(indexPtr) && !regWrValid && $stable(wrLatch) && !memRdReq))
    else $error("state changed with chip select high");

  a_index_load: assert property (@(posedge clock) disable iff (srst) // [R8]
    (wrEnd && !sel) |=> indexPtr == $past(din[7:0]))
    else $error("index pointer not loaded from select-0 write");

  a_reg_route: assert property (@(posedge clock) disable iff (srst) // [R9]
    regWrValid |-> (regWrIndex == indexPtr && regWrIndex != MEM_INDEX))
    else $error("register write not aimed at stored index");

  a_latch_drain: assert property (@(posedge clock) disable iff (srst) // [R11]
    (wrLatchFull && fifoInReady && !pixelLoad) |=> !wrLatchFull)
    else $error("write latch did not drain into memory path");

  a_read_stale: assert property (@(posedge clock) disable iff (srst) // [R12]
    (rdStart && sel && memTarget && !memRdValid) |=> hostDataOut == $past(readWord))
    else $error("memory read did not return the read latch");

  a_strobe_style: assert property (@(posedge clock) disable iff (srst) // [R14]
    hostDataOe |-> $past(style ? (wrs && rds) : !rds))
    else $error("data driven outside the read strobe of the chosen style");

  a_format_18: assert property (@(posedge clock) disable iff (srst) // [R15]
    (wrEnd && sel && memTarget && !videoPortEnable && fmt == dhp_pkg::FMT_18) |=> wrLatch == $past(din))
    else $error("18-bit collective pixel not captured whole");

endmodule // dhp_host_port
`default_nettype wire

// ### verification/dhp_host_model.sv
// Host processor model that drives the parallel bus pins.
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
  // Clock and strobe style
  input wire logic clock,
  input wire logic style,
  // Bus pins
  output logic csN,
  output logic sel,
  output logic wrStb,
  output logic rdStb,
  output logic [17:0] data,
  output logic sdo,
  input wire logic [17:0] dataBack
);
  initial
  begin
    csN = 1'b1;
    sel = 1'b0;
    wrStb = 1'b1;
    rdStb = 1'b1;
    data = 18'h0;
    sdo = 1'b0;
  end

  // Phases last at least 2 clocks so the pin synchronisers never merge edges
  task automatic xfer(input logic rd, input logic s, input logic [17:0] d, input logic csOff,
                      output logic [17:0] q);
    @(posedge clock);
    wrStb <= ~style;
    rdStb <= ~style | rd;
    sel <= s;
    data <= rd ? ~d : d;
    repeat (4) @(posedge clock);
    csN <= csOff;
    repeat (2) @(posedge clock);
    if (style)
      wrStb <= 1'b1;
    else if (rd)
      rdStb <= 1'b0;
    else
      wrStb <= 1'b0;
    repeat (8) @(posedge clock);
    q = dataBack;
    wrStb <= ~style;
    // An 8080 read strobe must end while chip select is still low, or the fetch is lost
    rdStb <= style ? rd : 1'b1;
    // Direction and chip select move only after the strobe has settled
    repeat (4) @(posedge clock);
    csN <= 1'b1;
    rdStb <= 1'b1;
    sel <= ~s;
    data <= ~d;
    repeat (4) @(posedge clock);
  endtask

  // Serial frame, MSB first, shifted on the rising select pin; phases of 5 clocks
  task automatic sframe(input logic [23:0] frame);
    @(posedge clock);
    csN <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      repeat (5) @(posedge clock);
      sel <= 1'b0;
      sdo <= frame[i];
      repeat (5) @(posedge clock);
      sel <= 1'b1;
    end
    repeat (5) @(posedge clock);
    csN <= 1'b1;
    sel <= 1'b0;
  endtask
endmodule // dhp_host_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the display host register port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic csN, sel, wrStb, rdStb, style, regWrValid, memWrValid, memWrReady, memRdReq, memRdValid;
  logic oe, sdi;
  logic [1:0] famStrap;
  logic [2:0] fmtStrap;
  logic [7:0] regWrIndex;
  logic [15:0] regWrData;
  logic [17:0] hostIn, hostOut, memWrData, memRdData, rdWord, q;
  logic [23:0] regQ[$];
  logic [17:0] memQ[$];
  int error_cnt, checks_done, rdReqs, n0, oeCnt;

  dhp_host_port DUT (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chipSelectN(csN), .regOrDataSelect(sel), .writeOrEnableStrobe(wrStb),
    .readOrDirectionStrobe(rdStb), .hostDataIn(hostIn), .hostDataOut(hostOut), .hostDataOe(oe),
    .serialDataIn(sdi), .interfaceFamilyStraps(famStrap), .busFormatStraps(fmtStrap),
    .strobeStyleSelect(style), .regWrValid(regWrValid), .regWrIndex(regWrIndex),
    .regWrData(regWrData), .regRdData(16'hbeef), .memWrValid(memWrValid), .memWrData(memWrData),
    .memWrReady(memWrReady), .memRdReq(memRdReq), .memRdData(memRdData), .memRdValid(memRdValid)
  );

  dhp_host_model host (
    .clock(clock), .style(style), .csN(csN), .sel(sel), .wrStb(wrStb), .rdStb(rdStb),
    .data(hostIn), .sdo(sdi), .dataBack(hostOut)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Frame memory stand-in; idle read data flips so a stale value never matches
  always @(posedge clock)
  begin
    memRdValid <= memRdReq === 1'b1;
    memRdData <= memRdReq === 1'b1 ? rdWord : ~memRdData;
    if (memRdReq === 1'b1)
    begin
      rdWord <= rdWord + 18'h01111;
      rdReqs++;
    end
    if (memWrValid === 1'b1 && memWrReady === 1'b1)
      memQ.push_back(memWrData);
    if (regWrValid === 1'b1)
      regQ.push_back({regWrIndex, regWrData});
    if (oe === 1'b1)
      oeCnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat();
    apb(1'b0, dhp_pkg::ADDR_STATUS, 32'h0);
  endtask

  task automatic wr(input logic s, input logic [17:0] d);
    host.xfer(1'b0, s, d, 1'b0, q);
  endtask

  task automatic rd(input logic s);
    host.xfer(1'b1, s, 18'h0, 1'b0, q);
  endtask

  // Straps pass synchronisers, so let them settle before traffic
  task automatic setFmt(input logic [2:0] f);
    fmtStrap <= f;
    repeat (8) @(posedge clock);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    famStrap = 2'h1;
    fmtStrap = 3'h2;
    style = 1'b0;
    memWrReady = 1'b1;
    memRdData = 18'h0;
    memRdValid = 1'b0;
    rdWord = 18'h15a5a;
    error_cnt = 0;
    checks_done = 0;
    rdReqs = 0;
    oeCnt = 0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    repeat (6) @(posedge clock);
    apb(1'b0, dhp_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h0, "ctrl reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
    apb(1'b1, dhp_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, dhp_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h1, "ctrl write");
    apb(1'b1, dhp_pkg::ADDR_CTRL, 32'h0);
    stat();
    chk({22'h0, r[17:8]}, 32'h49, "straps");
    done("apb");
    wr(1'b0, 18'h00005);
    stat();
    chk({24'h0, r[7:0]}, 32'h5, "index");
    n0 = oeCnt;
    rd(1'b0);
    chk({14'h0, q}, 32'h5, "host status");
    chk(oeCnt - n0, 32'h8, "drive window");
    wr(1'b1, 18'h01234);
    rd(1'b1);
    chk({16'h0, q[15:0]}, 32'hbeef, "reg read");
    chk({8'h0, regQ.pop_front()}, 32'h51234, "reg write");
    done("index");
    host.xfer(1'b0, 1'b0, 18'h00077, 1'b1, q);
    host.xfer(1'b0, 1'b1, 18'h0abcd, 1'b1, q);
    stat();
    chk({24'h0, r[7:0]}, 32'h5, "cs high index");
    chk(regQ.size(), 32'h0, "cs high reg");
    done("chipselect");
    wr(1'b0, 18'h00022);
    memWrReady <= 1'b0;
    for (int i = 0; i < 6; i++)
      wr(1'b1, 18'h20000 + 18'(i));
    stat();
    chk({30'h0, r[16:15]}, 32'h3, "overrun");
    memWrReady <= 1'b1;
    repeat (20) @(posedge clock);
    // Fifth pixel sat in the full latch and was replaced by the sixth
    for (int i = 0; i < 6; i++)
      if (i != 4)
        chk({14'h0, memQ.pop_front()}, 32'h20000 + i, "drain");
    chk(memQ.size(), 32'h0, "drain count");
    apb(1'b1, dhp_pkg::ADDR_STATUS, 32'h8000);
    stat();
    chk({30'h0, r[16:15]}, 32'h0, "overrun clear");
    done("fifo");
    setFmt(3'h1);
    wr(1'b0, 18'h00022);
    wr(1'b1, 18'h0abcd);
    wr(1'b1, 18'h00003);
    setFmt(3'h3);
    wr(1'b0, 18'h00022);
    wr(1'b1, 18'h3fffc);
    wr(1'b1, 18'h00080);
    wr(1'b1, 18'h2a304);
    setFmt(3'h0);
    wr(1'b0, 18'h00022);
    wr(1'b1, 18'h01234);
    repeat (12) @(posedge clock);
    chk({14'h0, memQ.pop_front()}, {14'h0, 16'habcd, 2'h3}, "16+2");
    chk({14'h0, memQ.pop_front()}, {14'h0, 6'h3f, 6'h20, 6'h01}, "bytes");
    chk(memQ.size(), 32'h1, "16 bit");
    chk({14'h0, memQ.pop_front()}, {14'h0, 6'h04, 6'h11, 6'h29}, "16 widen");
    setFmt(3'h6);
    stat();
    chk({31'h0, r[17]}, 32'h1, "serial");
    host.sframe(24'h721234);
    repeat (8) @(posedge clock);
    chk({14'h0, memQ.pop_front()}, {14'h0, 6'h04, 6'h11, 6'h29}, "serial pixel");
    setFmt(3'h2);
    done("formats");
    apb(1'b1, dhp_pkg::ADDR_CTRL, 32'h1);
    wr(1'b0, 18'h00022);
    wr(1'b1, 18'h11111);
    wr(1'b0, 18'h00005);
    wr(1'b1, 18'h00042);
    chk(memQ.size(), 32'h0, "video drop");
    chk({8'h0, regQ.pop_front()}, 32'h50042, "video reg");
    apb(1'b1, dhp_pkg::ADDR_CTRL, 32'h0);
    done("video");
    wr(1'b0, 18'h00022);
    n0 = rdReqs;
    rd(1'b1);
    chk(rdReqs - n0, 32'h1, "read fetch");
    rd(1'b1);
    chk({14'h0, q}, 32'h15a5a, "read latch");
    done("read");
    style <= 1'b1;
    wr(1'b0, 18'h00009);
    rd(1'b0);
    chk({14'h0, q}, 32'h9, "6800 status");
    style <= 1'b0;
    done("style");
    famStrap <= 2'h2;
    wr(1'b0, 18'h00033);
    stat();
    chk({17'h0, r[14], 6'h0, r[7:0]}, 32'h9, "family off");
    famStrap <= 2'h1;
    done("family");
    close_out();
  end
endmodule // testbench
`default_nettype wire
